// ===== rtl/dpram_host_regs.svh
// Timing constants and field positions for the dual-port memory host controller
`ifndef DPRAM_HOST_REGS_SVH
`define DPRAM_HOST_REGS_SVH

`define ADDR_W            16
`define DATA_W            8
`define FLAG_IDX_W        3
`define CLK_PERIOD_PS     5000
// Times in ps, as printed in ns times 1000
`define T_ADDR_SETUP_PS   0
`define T_WRITE_PULSE_PS  12000
`define T_TURNOFF_PS      10000
`define T_DATA_SETUP_PS   10000
`define T_READ_ACCESS_PS  15000
`define T_BUSY_DATA_PS    15000
`define T_SEM_W2R_PS      5000
`define T_WRITE_HOLD_PS   12000
`define T_DATA_HOLD_PS    0
// Least times round up, none below one cycle
`define CYC_UP(t)         (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_MIN1(t)       ((`CYC_UP(t) < 1) ? 1 : `CYC_UP(t))
`define CNT_W             4
`define MAILBOX_LEFT      16'hFFFE
`define MAILBOX_RIGHT     16'hFFFF
`define FLAG_BIT          0

`endif

// ===== rtl/dpram_host_pkg.sv
// Types shared by the dual-port memory host controller
package dpram_host_pkg;

  typedef struct packed {
    logic        write;    // 1 write, 0 read
    logic        flag;     // 1 semaphore flag, 0 array
    logic        oe_hold;  // keep output drive enabled during write
    logic [15:0] addr;
    logic [7:0]  wdata;
  } req_type;

  typedef struct packed {
    logic        port_sel_n;
    logic        flag_select_n;
    logic        write_n;
    logic        out_en_n;
    logic [15:0] addr;
  } pins_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_RECOVER,
    ST_READ,
    ST_GAP
  } state_type;

endpackage : dpram_host_pkg

// ===== rtl/sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module sync3 (
  input  wire logic sys_clk,  // System clock
  input  wire logic reset_n,  // Async reset, active low
  input  wire logic din,      // Asynchronous input
  output logic      dout      // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  logic out_next;

  always_comb begin
    out_next = out_reg;
    if (s2_reg == s3_reg) begin
      out_next = s3_reg;
    end
  end

  // Idle pin level of the active-low inputs is high
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      out_reg <= 1'b1;
    end else begin
      s1_reg  <= din;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : sync3

// ===== rtl/dpram_host.sv
// Host controller driving one port of the dual-port static memory
`timescale 1ns/1ps
`include "dpram_host_regs.svh"
module dpram_host (
  input  wire logic                   sys_clk,        // 200 MHz clock
  input  wire logic                   reset_n,        // Async reset, active low
  input  wire logic                   req_valid,      // Request strobe
  input  wire dpram_host_pkg::req_type req,           // Request fields
  output logic                        req_ready,      // Idle, request taken
  output logic                        done,           // One-cycle completion pulse
  output logic [`DATA_W-1:0]          rdata,          // Read data, valid with done
  output logic                        flag_state,     // Semaphore bit, valid with done
  output logic                        mailbox_irq,    // Synchronised interrupt, high active
  output logic                        port_sel_n,     // Port select pin
  output logic                        flag_select_n,  // Semaphore select pin
  output logic                        write_n,        // Write strobe pin
  output logic                        out_en_n,       // Output enable pin
  output logic [`ADDR_W-1:0]          addr,           // Address pins
  input  wire logic [`DATA_W-1:0]     data_in,        // Data pins, input side
  output logic [`DATA_W-1:0]          data_out,       // Data pins, output side
  output logic                        data_oe_n,      // Data drive enable, low drives
  input  wire logic                   busy_n,         // Busy pin
  input  wire logic                   int_n           // Interrupt pin
);
  localparam int PULSE_A = `CYC_MIN1(`T_WRITE_PULSE_PS);
  localparam int PULSE_B = `CYC_MIN1(`T_TURNOFF_PS + `T_DATA_SETUP_PS);
  localparam int SETUP_C = `CYC_MIN1(`T_ADDR_SETUP_PS);
  localparam int READ_C  = `CYC_MIN1(`T_READ_ACCESS_PS > `T_BUSY_DATA_PS ?
                                     `T_READ_ACCESS_PS : `T_BUSY_DATA_PS);
  localparam int GAP_C   = `CYC_MIN1(`T_SEM_W2R_PS);
  localparam int HOLD_C  = `CYC_MIN1(`T_WRITE_HOLD_PS);
  localparam int HOLD_D  = `CYC_MIN1(`T_DATA_HOLD_PS);

  localparam logic [`CNT_W-1:0] PULSE_OE  = `CNT_W'(PULSE_A > PULSE_B ? PULSE_A : PULSE_B);
  localparam logic [`CNT_W-1:0] PULSE_OFF = `CNT_W'(PULSE_A);
  localparam logic [`CNT_W-1:0] SETUP_N   = `CNT_W'(SETUP_C);
  localparam logic [`CNT_W-1:0] READ_N    = `CNT_W'(READ_C);
  localparam logic [`CNT_W-1:0] GAP_N     = `CNT_W'(GAP_C);
  localparam logic [`CNT_W-1:0] HOLD_N    = `CNT_W'(HOLD_C);
  localparam logic [`CNT_W-1:0] DHOLD_N   = `CNT_W'(HOLD_D);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic busy_s;
  logic int_s;

  sync3 u_busy_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     (busy_n),
    .dout    (busy_s)
  );

  sync3 u_int_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     (int_n),
    .dout    (int_s)
  );

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  dpram_host_pkg::state_type state_reg;
  dpram_host_pkg::state_type state_next;
  dpram_host_pkg::req_type   cur_reg;
  dpram_host_pkg::req_type   cur_next;
  dpram_host_pkg::pins_type  pins_reg;
  dpram_host_pkg::pins_type  pins_next;
  logic [`CNT_W-1:0]         cnt_reg;
  logic [`CNT_W-1:0]         cnt_next;
  logic                      last_sem_wr_reg;
  logic                      last_sem_wr_next;
  logic [`DATA_W-1:0]        wdata_reg;
  logic [`DATA_W-1:0]        wdata_next;
  logic                      doe_n_reg;
  logic                      doe_n_next;
  logic [`DATA_W-1:0]        rdata_reg;
  logic [`DATA_W-1:0]        rdata_next;
  logic                      flag_reg;
  logic                      flag_next;
  logic                      done_reg;
  logic                      done_next;
  logic                      irq_reg;

  // Select pattern for the access kind
  function automatic logic [1:0] sel_of(input logic is_flag);
    sel_of = is_flag ? 2'b10 : 2'b01;
  endfunction : sel_of

  always_comb begin
    state_next       = state_reg;
    cur_next         = cur_reg;
    pins_next        = pins_reg;
    cnt_next         = cnt_reg;
    last_sem_wr_next = last_sem_wr_reg;
    wdata_next       = wdata_reg;
    doe_n_next       = doe_n_reg;
    rdata_next       = rdata_reg;
    flag_next        = flag_reg;
    done_next        = 1'b0;
    case (state_reg)
      dpram_host_pkg::ST_IDLE: begin
        if (req_valid) begin
          cur_next  = req;
          // Address moves only with both strobes high
          pins_next.addr = req.addr;
          if (last_sem_wr_reg && req.flag && !req.write) begin
            state_next = dpram_host_pkg::ST_GAP;
            cnt_next   = GAP_N;
          end else begin
            state_next = dpram_host_pkg::ST_SETUP;
            cnt_next   = SETUP_N;
          end
        end
      end
      dpram_host_pkg::ST_GAP: begin
        if (cnt_reg <= `CNT_W'(1)) begin
          state_next = dpram_host_pkg::ST_SETUP;
          cnt_next   = SETUP_N;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      dpram_host_pkg::ST_SETUP: begin
        {pins_next.port_sel_n, pins_next.flag_select_n} = sel_of(cur_reg.flag);
        // Selects go down one cycle ahead of the strobe
        if (cnt_reg <= `CNT_W'(1) &&
            {pins_reg.port_sel_n, pins_reg.flag_select_n} == sel_of(cur_reg.flag)) begin
          if (cur_reg.write) begin
            // Strobe falls with select already down, memory stays off the bus unless oe_hold is set
            pins_next.write_n  = 1'b0;
            pins_next.out_en_n = !cur_reg.oe_hold;
            wdata_next         = cur_reg.flag ?
                                 {{(`DATA_W-1){1'b1}}, cur_reg.wdata[`FLAG_BIT]} :
                                 cur_reg.wdata;
            doe_n_next         = 1'b0;
            cnt_next           = cur_reg.oe_hold ? PULSE_OE : PULSE_OFF;
            state_next         = dpram_host_pkg::ST_PULSE;
          end else begin
            pins_next.out_en_n = 1'b0;
            cnt_next           = READ_N;
            state_next         = dpram_host_pkg::ST_READ;
          end
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      dpram_host_pkg::ST_PULSE: begin
        if (!busy_s && !cur_reg.flag) begin
          // Far side holds the word; keep strobe low and restart hold
          cnt_next = HOLD_N;
        end else if (cnt_reg <= `CNT_W'(1)) begin
          pins_next.write_n       = 1'b1;
          pins_next.port_sel_n    = 1'b1;
          pins_next.flag_select_n = 1'b1;
          pins_next.out_en_n      = 1'b1;
          last_sem_wr_next        = cur_reg.flag;
          cnt_next                = DHOLD_N;
          state_next              = dpram_host_pkg::ST_RECOVER;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      dpram_host_pkg::ST_RECOVER: begin
        // Data stays driven one cycle past the strobe rise
        if (cnt_reg <= `CNT_W'(1)) begin
          doe_n_next = 1'b1;
          done_next  = 1'b1;
          state_next = dpram_host_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      dpram_host_pkg::ST_READ: begin
        // Busy low stretches the wait for the far write to land
        if (!busy_s) begin
          cnt_next = READ_N;
        end else if (cnt_reg <= `CNT_W'(1)) begin
          rdata_next              = data_in;
          flag_next               = data_in[`FLAG_BIT];
          pins_next.out_en_n      = 1'b1;
          pins_next.port_sel_n    = 1'b1;
          pins_next.flag_select_n = 1'b1;
          last_sem_wr_next        = 1'b0;
          done_next               = 1'b1;
          state_next              = dpram_host_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - `CNT_W'(1);
        end
      end
      default: begin
        state_next = dpram_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg       <= dpram_host_pkg::ST_IDLE;
      cur_reg         <= '0;
      pins_reg        <= {1'b1, 1'b1, 1'b1, 1'b1, {`ADDR_W{1'b0}}};
      cnt_reg         <= '0;
      last_sem_wr_reg <= 1'b0;
      wdata_reg       <= '0;
      doe_n_reg       <= 1'b1;
      rdata_reg       <= '0;
      flag_reg        <= 1'b0;
      done_reg        <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      state_reg       <= state_next;
      cur_reg         <= cur_next;
      pins_reg        <= pins_next;
      cnt_reg         <= cnt_next;
      last_sem_wr_reg <= last_sem_wr_next;
      wdata_reg       <= wdata_next;
      doe_n_reg       <= doe_n_next;
      rdata_reg       <= rdata_next;
      flag_reg        <= flag_next;
      done_reg        <= done_next;
      irq_reg         <= !int_s;
    end
  end

  // Ready cannot come straight from a flop-free decode; idle state is registered
  logic ready_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == dpram_host_pkg::ST_IDLE) && !(req_valid && ready_reg);
    end
  end

  assign req_ready     = ready_reg;
  assign done          = done_reg;
  assign rdata         = rdata_reg;
  assign flag_state    = flag_reg;
  assign mailbox_irq   = irq_reg;
  assign port_sel_n    = pins_reg.port_sel_n;
  assign flag_select_n = pins_reg.flag_select_n;
  assign write_n       = pins_reg.write_n;
  assign out_en_n      = pins_reg.out_en_n;
  assign addr          = pins_reg.addr;
  assign data_out      = wdata_reg;
  assign data_oe_n     = doe_n_reg;
endmodule : dpram_host

// ===== dv/dpram_host_monitor.sv
// Assertion checker for the dual-port memory host controller
`timescale 1ns/1ps
`include "dpram_host_regs.svh"
module dpram_host_monitor (
  input wire logic               sys_clk,       // Clock
  input wire logic               reset_n,       // Reset, active low
  input wire logic               port_sel_n,    // Array select pin
  input wire logic               flag_select_n, // Flag select pin
  input wire logic               write_n,       // Write strobe pin
  input wire logic               out_en_n,      // Output enable pin
  input wire logic [`ADDR_W-1:0] addr,          // Address pins
  input wire logic [`DATA_W-1:0] data_out,      // Write data
  input wire logic               data_oe_n,     // Data drive, low drives
  input wire logic               busy_n,        // Busy pin
  input wire logic               int_n,         // Interrupt pin
  input wire logic               mailbox_irq    // Synchronised interrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_sel_exclusive: assert property (port_sel_n || flag_select_n)
    else $error("both selects low");
  a_write_selected: assert property (!write_n |-> port_sel_n != flag_select_n)
    else $error("write strobe without one select");
  a_sel_steady: assert property (!write_n && !$past(write_n) |->
    $stable(port_sel_n) && $stable(flag_select_n) && $stable(addr))
    else $error("selection moved during write");
  a_addr_quiet: assert property ($changed(addr) |-> $past(write_n) || $past(port_sel_n))
    else $error("address moved with write and select low");
  a_pulse_width: assert property ($rose(write_n) |-> !$past(write_n, 3))
    else $error("write pulse under three cycles");
  a_pulse_driven: assert property ($rose(write_n) && !$past(out_en_n) |-> !$past(write_n, 4))
    else $error("driven write pulse under four cycles");
  a_data_hold: assert property ($rose(write_n) |-> !data_oe_n && $stable(data_out))
    else $error("write data released before write end");
  a_flag_gap: assert property ($rose(write_n) && !$past(flag_select_n) |-> out_en_n[*2])
    else $error("flag read too soon after flag write");
  a_busy_hold: assert property ($rose(busy_n) && !write_n |-> !write_n[*3])
    else $error("write ended too soon after busy");
  a_irq_sync: assert property ($fell(int_n) |-> !mailbox_irq ##1 !mailbox_irq ##[1:4] mailbox_irq)
    else $error("interrupt not synchronised in time");

  c_array_write: cover property ($fell(write_n) && !port_sel_n);
  c_busy_write: cover property (!write_n && !busy_n);
  c_flag_write: cover property ($rose(write_n) && !$past(flag_select_n));
  c_irq: cover property ($rose(mailbox_irq));
endmodule : dpram_host_monitor

bind dpram_host dpram_host_monitor i_mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .port_sel_n(port_sel_n), .flag_select_n(flag_select_n), .write_n(write_n),
  .out_en_n(out_en_n), .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
  .busy_n(busy_n), .int_n(int_n), .mailbox_irq(mailbox_irq));

// ===== dv/dpram_port_model.sv
// Behavioural model of one port of the dual-port memory
`timescale 1ns/1ps
`include "dpram_host_regs.svh"
module dpram_port_model (
  input  wire logic               port_sel_n,    // Array select
  input  wire logic               flag_select_n, // Flag select
  input  wire logic               write_n,       // Write strobe
  input  wire logic               out_en_n,      // Output enable
  input  wire logic [`ADDR_W-1:0] addr,          // Address
  input  wire logic [`DATA_W-1:0] data_out,      // Host drive value
  input  wire logic               data_oe_n,     // Host drive enable
  input  wire logic               busy_n,        // Write inhibit input
  output logic      [`DATA_W-1:0] data_in        // Resolved data bus
);
  logic [`DATA_W-1:0] mem [0:(1 << `ADDR_W)-1];
  logic [7:0]         flags = 8'hFF;
  logic               pa = 1'b0;
  logic               ps = 1'b0;
  logic               pf;
  logic [7:0]         pd;
  logic [7:0]         rd_val;
  logic [15:0]        pad;
  logic [2:0]         psa;
  logic               rd_sel;
  logic               sel_ok;
  logic               oe_ok;

  // Commit at the end of the overlap, with the data still held there
  always @* begin
    if (!write_n && !port_sel_n && flag_select_n) begin
      pa = 1'b1;
      pad = addr;
      pd = data_in;
    end else if (pa) begin
      if (busy_n) mem[pad] = pd;
      pa = 1'b0;
    end
    if (!write_n && !flag_select_n && port_sel_n) begin
      ps = 1'b1;
      psa = addr[2:0];
      pf = data_in[0];
    end else if (ps) begin
      flags[psa] = pf;
      ps = 1'b0;
    end
    rd_sel = write_n && (port_sel_n != flag_select_n);
    if (!port_sel_n) rd_val = mem[addr];
    else rd_val = {8{flags[addr[2:0]]}};
  end

  // Single port: no far-side write, so the busy release delay is zero
  assign #15 sel_ok = rd_sel;
  assign #10 oe_ok = !out_en_n;
  // Undriven bus shows the inverse rather than a stale value
  assign data_in = !data_oe_n ? data_out :
                   (rd_sel && !out_en_n && sel_ok && oe_ok) ? rd_val : ~rd_val;
endmodule : dpram_port_model

// ===== dv/dpram_host_tb_top.sv
// Self-checking testbench for the dual-port memory host controller
`timescale 1ns/1ps
`include "dpram_host_regs.svh"
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module dpram_host_tb_top;
  logic                    sys_clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    req_valid = 1'b0;
  logic                    busy_n = 1'b1;
  logic                    int_n = 1'b1;
  dpram_host_pkg::req_type req = '0;
  logic                    req_ready, done, flag_state, mailbox_irq;
  logic                    port_sel_n, flag_select_n, write_n, out_en_n, data_oe_n;
  logic [`DATA_W-1:0]      rdata, data_in, data_out;
  logic [`ADDR_W-1:0]      addr;
  int                      miscompares = 0;
  int                      comparisons = 0;
  int                      cyc;

  always #2.5 sys_clk = ~sys_clk;

  dpram_host i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .rdata(rdata), .flag_state(flag_state),
    .mailbox_irq(mailbox_irq), .port_sel_n(port_sel_n), .flag_select_n(flag_select_n),
    .write_n(write_n), .out_en_n(out_en_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .busy_n(busy_n), .int_n(int_n));
  dpram_port_model i_mem (.port_sel_n(port_sel_n), .flag_select_n(flag_select_n),
    .write_n(write_n), .out_en_n(out_en_n), .addr(addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .busy_n(busy_n), .data_in(data_in));

  task automatic run_op(input logic wr, fl, oeh, input logic [15:0] a, input logic [7:0] d);
    cyc = 0;
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{write: wr, flag: fl, oe_hold: oeh, addr: a, wdata: d};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end while (done !== 1'b1 && cyc < 100);
    if (done !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask : run_op

  task automatic test_array();
    run_op(1'b1, 1'b0, 1'b0, 16'h1234, 8'h5A);
    `CHECK("write cycles", 6, cyc)
    run_op(1'b0, 1'b0, 1'b0, 16'h1234, 8'h00);
    `CHECK("read cycles", 5, cyc)
    `CHECK("read data", 8'h5A, rdata)
    run_op(1'b1, 1'b0, 1'b1, 16'hFFFE, 8'hA5);
    `CHECK("driven write cycles", 7, cyc)
    run_op(1'b0, 1'b0, 1'b0, 16'hFFFE, 8'h00);
    `CHECK("driven write data", 8'hA5, rdata)
    $display("array test done");
  endtask : test_array

  task automatic test_flags();
    for (int i = 0; i < 8; i++) begin
      run_op(1'b1, 1'b1, 1'b0, 16'(i), 8'(i));
      run_op(1'b0, 1'b1, 1'b0, 16'(i), 8'h00);
      `CHECK("flag cycles", 6, cyc)
      `CHECK("flag data", {8{1'(i)}}, rdata)
      `CHECK("flag state", 1'(i), flag_state)
    end
    run_op(1'b0, 1'b1, 1'b0, 16'h0000, 8'h00);
    `CHECK("flag zero kept", 8'h00, rdata)
    $display("flag test done");
  endtask : test_flags

  task automatic test_busy();
    fork
      run_op(1'b1, 1'b0, 1'b0, 16'h0042, 8'hC3);
      begin
        wait (req_valid);
        @(posedge sys_clk);
        busy_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        busy_n <= 1'b1;
      end
    join
    `CHECK("stalled write longer", 1'b1, 1'(cyc > 10))
    run_op(1'b0, 1'b0, 1'b0, 16'h0042, 8'h00);
    `CHECK("stalled write data", 8'hC3, rdata)
    $display("busy test done");
  endtask : test_busy

  task automatic test_irq();
    @(posedge sys_clk);
    int_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHECK("irq raised", 1'b1, mailbox_irq)
    @(posedge sys_clk);
    int_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHECK("irq cleared", 1'b0, mailbox_irq)
    $display("irq test done");
  endtask : test_irq

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    test_array();
    test_flags();
    test_busy();
    test_irq();
    finish_test();
  end

  // Whole run needs a few hundred cycles; 5000 leaves wide margin
  initial begin
    #(5 * 5000);
    miscompares++;
    finish_test();
  end
endmodule : dpram_host_tb_top
